// [include/spo_pkg.sv]
// Purpose: Shared constants, types and helpers for the scaled parallel output
// Assumes: 20 MHz single clock, synchronous active-low reset
package spo_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_NS     = 50;
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned BAUD       = 115_200;
  localparam logic [7:0]  BIT_CYC    = 8'(CLK_HZ / BAUD);
  localparam logic [7:0]  HALF_CYC   = 8'(CLK_HZ / BAUD / 2);
  localparam int unsigned MS_NS      = 1_000_000;
  localparam int unsigned MS_CYC_DEF = MS_NS / CLK_NS;
  localparam int unsigned SETTLE_NS  = 200;
  localparam logic [3:0]  SETTLE_CYC = 4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [6:0]  DIV_STEPS  = 7'h40;
  localparam logic [2:0]  UA_LAST    = 3'h4;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] ADR_MODE = 4'h0, ADR_RTYPE = 4'h1, ADR_DIR = 4'h2;
  localparam logic [3:0] ADR_MULT = 4'h3, ADR_DIVR = 4'h4, ADR_OFFS = 4'h5;
  localparam logic [3:0] ADR_LIN = 4'h6, ADR_RETAIN = 4'h7, ADR_DEFAULTS = 4'h8;
  localparam logic [3:0] ADR_PIN = 4'h9, ADR_UPD = 4'hA, ADR_GAIN = 4'hB;
  localparam logic [3:0] ADR_STATUS = 4'hC, ADR_MASK = 4'hD, ADR_RESULT = 4'hE;
  localparam logic [3:0] ADR_RETAINED = 4'hF;
  // ************************************************************
  // Codes and fields
  // ************************************************************
  localparam logic [2:0] MODE_NONE = 3'h0, MODE_FREQ = 3'h1, MODE_CNT = 3'h2;
  localparam logic [2:0] MODE_SSI = 3'h3, MODE_SS = 3'h4, RTYPE_MAX = 3'h4;
  localparam logic [1:0] LIN_OFF = 2'h0, LIN_Q1 = 2'h1, LIN_Q4 = 2'h2;
  localparam int PIN_ERR_EN = 0, PIN_STB_EN = 1, PIN_ERR_HI = 2, PIN_STB_HI = 3;
  localparam int EV_MAX = 0, EV_MIN = 1, EV_DZ = 2, EV_UPD = 3, EV_W = 4;
  localparam int TOP_BIT = 24, NEXT_BIT = 23, LIN_FRAC = 16;
  localparam logic [31:0] DEF_MULT = 32'h0000_0001, DEF_DIVR = 32'h0000_0001;
  localparam logic [31:0] DEF_OFFS = 32'h0000_0000, DEF_GAIN = 32'h0001_0000;
  localparam logic [15:0] DEF_UPD  = 16'h0064;
  localparam logic [31:0] MULT_MAX = 32'h05F5_E0FF, MULT_MIN = 32'hFA0A_1F01;
  localparam logic [31:0] DIVR_MIN = 32'hFF67_6981, OFFS_MAX = 32'h0098_967F;
  localparam logic [63:0] LIM0 = 64'h0000_0000_00FF_FFFF;
  localparam logic [63:0] LIM1 = 64'h0000_0000_007F_FFFF;
  localparam logic [63:0] LIM2 = 64'h0000_0000_003F_FFFF;
  localparam logic [24:0] DMASK0 = 25'h1FF_FFFF, DMASK1 = 25'h0FF_FFFF;
  localparam logic [24:0] DMASK2 = 25'h07F_FFFF;

  typedef enum logic [1:0] {ST_STABLE, ST_DROP, ST_LOAD, ST_SETTLE} spo_out_e;
  typedef enum logic [1:0] {C_IDLE, C_MUL, C_DIV, C_OUT} spo_calc_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spo_rx_e;

  function automatic logic [31:0] clamp32(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
    if ($signed(v) < $signed(lo)) return lo;
    if ($signed(v) > $signed(hi)) return hi;
    return v;
  endfunction

  // Flag count (0, 1, 2) picks the signed range of the data field
  function automatic logic signed [63:0] lim_max(input logic [1:0] nflag);
    return (nflag == 2'h0) ? LIM0 : (nflag == 2'h1) ? LIM1 : LIM2;
  endfunction

  function automatic logic [24:0] dmask(input logic [1:0] nflag);
    return (nflag == 2'h0) ? DMASK0 : (nflag == 2'h1) ? DMASK1 : DMASK2;
  endfunction
endpackage

// [logic/spo_uart_rx.sv]
// Purpose: Byte receiver for the parameter link
// Assumes: Line idles high, input synchronous to mclk_in
// Notes:   Bytes with a bad stop bit are dropped
`timescale 1ns/1ps
module spo_uart_rx import spo_pkg::*; (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       rx_in,
  output logic      [7:0] byte_out,
  output logic            byte_vld_out
);
  spo_rx_e    st;
  logic [7:0] cnt;
  logic [2:0] idx;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st           <= RX_IDLE;
      cnt          <= 8'h00;
      idx          <= 3'h0;
      byte_out     <= 8'h00;
      byte_vld_out <= 1'b0;
    end else begin
      byte_vld_out <= 1'b0;
      if (st != RX_IDLE && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else begin
        unique case (st)
          RX_IDLE: if (!rx_in) begin
            st  <= RX_START;
            cnt <= HALF_CYC;
          end
          RX_START: begin
            // Mid-bit recheck rejects glitches on the idle line
            st  <= rx_in ? RX_IDLE : RX_DATA;
            cnt <= BIT_CYC - 8'h01;
            idx <= 3'h0;
          end
          RX_DATA: begin
            byte_out <= {rx_in, byte_out[7:1]};
            cnt      <= BIT_CYC - 8'h01;
            idx      <= idx + 3'h1;
            if (idx == 3'h7) st <= RX_STOP;
          end
          RX_STOP: begin
            byte_vld_out <= rx_in;
            st           <= RX_IDLE;
          end
        endcase
      end
    end
  end
endmodule // spo_uart_rx

// [logic/spo_divider.sv]
// Purpose: Sequential signed divider, 64-bit by 32-bit
// Assumes: Divisor non-zero; caller waits for done
// Notes:   One quotient bit per cycle to keep area small
`timescale 1ns/1ps
module spo_divider import spo_pkg::*; (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic [63:0] num_in,
  input  wire logic [31:0] den_in,
  output logic      [63:0] quo_out,
  output logic             done_out
);
  logic [32:0] rem;
  logic [63:0] quo;
  logic [31:0] dmag;
  logic [6:0]  cnt;
  logic        neg;
  logic [32:0] next_rem;
  logic        next_bit;
  logic [63:0] next_quo;

  always_comb begin
    next_rem = {rem[31:0], quo[63]};
    next_bit = (next_rem >= {1'b0, dmag});
    if (next_bit) next_rem = next_rem - {1'b0, dmag};
    next_quo = {quo[62:0], next_bit};
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rem      <= '0;
      quo      <= '0;
      dmag     <= '0;
      cnt      <= '0;
      neg      <= 1'b0;
      quo_out  <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && cnt == 7'h00) begin
        rem  <= '0;
        quo  <= num_in[63] ? -num_in : num_in;
        dmag <= den_in[31] ? -den_in : den_in;
        neg  <= num_in[63] ^ den_in[31];
        cnt  <= DIV_STEPS;
      end else if (cnt != 7'h00) begin
        rem <= next_rem;
        quo <= next_quo;
        cnt <= cnt - 7'h01;
        if (cnt == 7'h01) begin
          quo_out  <= neg ? -next_quo : next_quo;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // spo_divider

// [logic/spo_top.sv]
// Purpose: Scales a measured value and drives it onto the parallel port
// Assumes: Register port and measurement input synchronous to mclk_in
// Notes:   Parameter link writes share the register write path
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module spo_top import spo_pkg::*; #(
  parameter int unsigned MS_CYC = MS_CYC_DEF
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        uart_rx_in,
  input  wire logic [31:0] meas_value_in,
  input  wire logic        meas_valid_in,
  input  wire logic        power_fail_in,
  output logic      [24:0] par_out,
  output logic      [2:0]  receiver_type_out,
  output logic             receiver_en_out,
  output logic             irq_out
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic [2:0]            mode_r, rtype_r;
  logic                  dir_r, retain_r;
  logic [31:0]           mult_r, divr_r, offs_r, gain_r, retained_r;
  logic [1:0]            lin_r;
  logic [3:0]            pin_r;
  logic [15:0]           upd_r, upd_lat, ms_cnt;
  logic [14:0]           ms_pre;
  logic [3:0]            settle;
  logic [EV_W-1:0]       status_r, mask_r, ev, next_status;
  logic [7:0]            rx_byte;
  logic                  rx_vld, ua_pend;
  logic [2:0]            ua_cnt;
  logic [3:0]            ua_addr, wa;
  logic [31:0]           ua_data, wd;
  logic                  we;
  spo_calc_e             cst;
  spo_out_e              st, next_st;
  logic signed [63:0]    sel_val, prod, quo, result, lin_val, sum;
  logic [63:0]           div_q;
  logic                  div_done, div_start, dz, err_now, hi, lo, mode_ok;
  logic [1:0]            nflag;
  logic                  err_en, stab_en;
  logic [24:0]           word, next_par;
  logic [31:0]           stab_run;

  // ************************************************************
  // Parameter link and write path
  // ************************************************************
  spo_uart_rx u_rx (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .rx_in        (uart_rx_in),
    .byte_out     (rx_byte),
    .byte_vld_out (rx_vld)
  );

  // Frame: address byte then four data bytes, low byte first
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ua_cnt  <= 3'h0;
      ua_pend <= 1'b0;
      ua_addr <= 4'h0;
      ua_data <= 32'h0000_0000;
    end else begin
      if (ua_pend && !wr_in) ua_pend <= 1'b0;
      if (rx_vld) begin
        if (ua_cnt == 3'h0) begin
          ua_addr <= rx_byte[3:0];
          ua_cnt  <= 3'h1;
        end else begin
          ua_data <= {rx_byte, ua_data[31:8]};
          ua_cnt  <= (ua_cnt == UA_LAST) ? 3'h0 : ua_cnt + 3'h1;
          if (ua_cnt == UA_LAST) ua_pend <= 1'b1;
        end
      end
    end
  end

  // Bus writes win; a held link write waits for a free cycle
  always_comb begin
    we = wr_in | ua_pend;
    wa = wr_in ? addr_in : ua_addr;
    wd = wr_in ? wdata_in : ua_data;
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || (we && wa == ADR_DEFAULTS && wd[0])) begin
      mode_r   <= MODE_NONE;
      rtype_r  <= 3'h0;
      dir_r    <= 1'b0;
      mult_r   <= DEF_MULT;
      divr_r   <= DEF_DIVR;
      offs_r   <= DEF_OFFS;
      lin_r    <= LIN_OFF;
      retain_r <= 1'b0;
      pin_r    <= 4'h0;
      upd_r    <= DEF_UPD;
      gain_r   <= DEF_GAIN;
      mask_r   <= '0;
    end else if (we) begin
      case (wa)
        ADR_MODE:   if (wd[2:0] <= MODE_SS) mode_r <= wd[2:0];
        ADR_RTYPE:  if (wd[2:0] <= RTYPE_MAX) rtype_r <= wd[2:0];
        ADR_DIR:    dir_r <= wd[0];
        ADR_MULT:   mult_r <= clamp32(wd, MULT_MIN, MULT_MAX);
        ADR_DIVR:   divr_r <= clamp32(wd, DIVR_MIN, MULT_MAX);
        ADR_OFFS:   offs_r <= clamp32(wd, DIVR_MIN, OFFS_MAX);
        ADR_LIN:    if (wd[1:0] <= LIN_Q4) lin_r <= wd[1:0];
        ADR_RETAIN: retain_r <= wd[0];
        ADR_PIN:    pin_r <= wd[3:0];
        ADR_UPD:    upd_r <= wd[15:0];
        ADR_GAIN:   gain_r <= wd;
        ADR_MASK:   mask_r <= wd[EV_W-1:0];
        default:    ;
      endcase
    end
  end

  always_comb begin
    err_en  = pin_r[PIN_ERR_EN];
    stab_en = pin_r[PIN_STB_EN];
    nflag   = {1'b0, err_en} + {1'b0, stab_en};
    mode_ok = (mode_r != MODE_NONE);
  end

  // ************************************************************
  // Scaling chain
  // ************************************************************
  always_comb begin
    sel_val = 64'($signed(meas_value_in));
    if (dir_r) sel_val = -sel_val;
    if (!mode_ok) sel_val = '0;
  end

  assign div_start = (cst == C_MUL) && (divr_r != 32'h0000_0000);

  spo_divider u_div (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .start_in (div_start),
    .num_in   (prod),
    .den_in   (divr_r),
    .quo_out  (div_q),
    .done_out (div_done)
  );

  // Correction gain is Q16; quadrant one leaves negatives untouched
  always_comb begin
    logic signed [95:0] sc;
    logic signed [63:0] mag;
    sum     = quo + 64'($signed(offs_r));
    mag     = sum[63] ? -sum : sum;
    sc      = 96'(mag) * 96'($signed(gain_r));
    lin_val = sum;
    if (lin_r == LIN_Q1 && !sum[63]) lin_val = sc[79:16];
    if (lin_r == LIN_Q4) lin_val = sum[63] ? -sc[79:16] : sc[79:16];
    hi = lin_val > lim_max(nflag);
    lo = lin_val < ~lim_max(nflag);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cst     <= C_IDLE;
      prod    <= '0;
      quo     <= '0;
      result  <= '0;
      dz      <= 1'b0;
      err_now <= 1'b0;
    end else begin
      unique case (cst)
        C_IDLE: if (meas_valid_in) begin
          prod <= sel_val * 64'($signed(mult_r));
          cst  <= C_MUL;
        end
        C_MUL: begin
          dz  <= (divr_r == 32'h0000_0000);
          quo <= '0;
          cst <= div_start ? C_DIV : C_OUT;
        end
        C_DIV: if (div_done) begin
          quo <= div_q;
          cst <= C_OUT;
        end
        C_OUT: begin
          result  <= lin_val;
          err_now <= hi | lo | dz;
          cst     <= C_IDLE;
        end
      endcase
    end
  end

  // Flops lose state on power loss; the host must save this value
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) retained_r <= 32'h0000_0000;
    else if (power_fail_in && retain_r && mode_r == MODE_CNT)
      retained_r <= result[31:0];
  end

  // ************************************************************
  // Parallel refresh sequencer
  // ************************************************************
  always_comb begin
    unique case (st)
      ST_STABLE: next_st = (ms_cnt >= upd_lat) ? ST_DROP : ST_STABLE;
      ST_DROP:   next_st = ST_LOAD;
      ST_LOAD:   next_st = ST_SETTLE;
      ST_SETTLE: next_st = (settle == 4'h0) ? ST_STABLE : ST_SETTLE;
    endcase
  end

  always_comb begin
    logic signed [63:0] r;
    r = result;
    if (r > lim_max(nflag)) r = lim_max(nflag);
    if (r < ~lim_max(nflag)) r = ~lim_max(nflag);
    word     = r[24:0] & dmask(nflag);
    next_par = par_out;
    if (st == ST_DROP) next_par = word;
    if (err_en && (!stab_en || st == ST_DROP))
      next_par[stab_en ? NEXT_BIT : TOP_BIT] = pin_r[PIN_ERR_HI] ? err_now : !err_now;
    if (stab_en)
      next_par[TOP_BIT] = pin_r[PIN_STB_HI] ~^ (next_st == ST_STABLE);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st      <= ST_STABLE;
      upd_lat <= DEF_UPD;
      ms_pre  <= 15'h0000;
      ms_cnt  <= 16'h0000;
      settle  <= 4'h0;
      par_out <= '0;
    end else begin
      st      <= next_st;
      par_out <= next_par;
      if (st == ST_STABLE) begin
        ms_pre <= (ms_pre == 15'(MS_CYC - 1)) ? 15'h0000 : ms_pre + 15'h0001;
        if (ms_pre == 15'(MS_CYC - 1)) ms_cnt <= ms_cnt + 16'h0001;
      end else begin
        ms_pre <= 15'h0000;
        ms_cnt <= 16'h0000;
      end
      if (st == ST_LOAD) settle <= SETTLE_CYC - 4'h1;
      else if (settle != 4'h0) settle <= settle - 4'h1;
      if (st == ST_SETTLE && next_st == ST_STABLE)
        upd_lat <= (upd_r == 16'h0000) ? 16'h0001 : upd_r;
    end
  end

  // ************************************************************
  // Status, interrupt and read port
  // ************************************************************
  always_comb begin
    ev              = '0;
    ev[EV_MAX]      = (cst == C_OUT) && hi;
    ev[EV_MIN]      = (cst == C_OUT) && lo;
    ev[EV_DZ]       = (cst == C_OUT) && dz;
    ev[EV_UPD]      = (st == ST_LOAD);
    next_status     = status_r;
    if (we && wa == ADR_STATUS) next_status = status_r & ~wd[EV_W-1:0];
    next_status     = next_status | ev; // Set beats clear
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      status_r          <= '0;
      irq_out           <= 1'b0;
      rdata_out         <= 32'h0000_0000;
      receiver_type_out <= 3'h0;
      receiver_en_out   <= 1'b0;
    end else begin
      status_r          <= next_status;
      irq_out           <= |(next_status & mask_r);
      receiver_type_out <= rtype_r;
      receiver_en_out   <= (mode_r == MODE_FREQ) || (mode_r == MODE_CNT);
      rdata_out         <= 32'h0000_0000;
      if (rd_in) begin
        case (addr_in)
          ADR_MODE:     rdata_out <= {29'h0, mode_r};
          ADR_RTYPE:    rdata_out <= {29'h0, rtype_r};
          ADR_DIR:      rdata_out <= {31'h0, dir_r};
          ADR_MULT:     rdata_out <= mult_r;
          ADR_DIVR:     rdata_out <= divr_r;
          ADR_OFFS:     rdata_out <= offs_r;
          ADR_LIN:      rdata_out <= {30'h0, lin_r};
          ADR_RETAIN:   rdata_out <= {31'h0, retain_r};
          ADR_PIN:      rdata_out <= {28'h0, pin_r};
          ADR_UPD:      rdata_out <= {16'h0, upd_r};
          ADR_GAIN:     rdata_out <= gain_r;
          ADR_STATUS:   rdata_out <= {28'h0, status_r};
          ADR_MASK:     rdata_out <= {28'h0, mask_r};
          ADR_RESULT:   rdata_out <= result[31:0];
          ADR_RETAINED: rdata_out <= retained_r;
          default:      rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || st != ST_STABLE) stab_run <= 32'h0000_0000;
    else stab_run <= stab_run + 32'h0000_0001;
  end

  sequence s_flag_fall;
    stab_en && st == ST_DROP && $past(st) == ST_STABLE;
  endsequence

  a_latch_edge_data: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_flag_fall |-> $stable(par_out & dmask(nflag)) ##1 st == ST_LOAD)
    else $error("data moved at stable flag edge");
  a_stable_min_len: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_flag_fall |-> 3 * stab_run >= 32'(upd_lat) * MS_CYC + 32'(SETTLE_CYC) + 2)
    else $error("stable phase too short");
  a_data_frozen: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st != ST_LOAD && $stable(pin_r)) |-> $stable(par_out & dmask(nflag)))
    else $error("data changed outside load");
  a_stable_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (stab_en && $stable(pin_r)) |->
      ((par_out[TOP_BIT] == pin_r[PIN_STB_HI]) == (st == ST_STABLE)))
    else $error("stable flag level wrong");
  a_word_loaded: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st == ST_DROP) ##1 $stable(pin_r) |-> (par_out & dmask(nflag)) == $past(word))
    else $error("parallel word not loaded");
  a_err_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (err_en && !stab_en) ##1 $stable(pin_r) |->
      par_out[TOP_BIT] == (pin_r[PIN_ERR_HI] ? $past(err_now) : !$past(err_now)))
    else $error("error bit level wrong");
  a_mode_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (cst == C_IDLE && meas_valid_in && !mode_ok) |=> prod == 64'h0000_0000_0000_0000)
    else $error("undefined mode not zero");
  a_range_err: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (cst == C_OUT && $stable(pin_r)) |=>
      err_now == ($past(dz) || result > lim_max(nflag) || result < ~lim_max(nflag)))
    else $error("range error flag wrong");
  a_calc_order: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (cst == C_MUL) |-> ##[1:70] (cst == C_OUT) ##1 (cst == C_IDLE))
    else $error("calculation did not finish");
  a_defaults_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (we && wa == ADR_DEFAULTS && wd[0]) |=>
      (mult_r == DEF_MULT && divr_r == DEF_DIVR && offs_r == DEF_OFFS && pin_r == 4'h0))
    else $error("defaults not restored");
  a_irq_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $stable(mask_r) |-> irq_out == |(status_r & mask_r))
    else $error("interrupt level wrong");
endmodule // spo_top

// [dv/spo_latch_model.sv]
// Purpose: Receiving controller that latches the parallel word
// Assumes: Stable flag on bit index 24, polarity given by stb_hi_in
// Notes:   Samples on the clock, so it sees the flag's leaving edge one cycle late
`timescale 1ns/1ps
module spo_latch_model (
  input  wire logic        mclk_in,
  input  wire logic        stb_hi_in,
  input  wire logic [24:0] par_in,
  output logic      [24:0] word_out,
  output logic      [7:0]  latch_cnt_out
);
  logic prev_act;
  initial begin
    word_out = '0;
    latch_cnt_out = '0;
    prev_act = 1'b0;
  end
  // Data must still be valid where the flag goes inactive
  always @(posedge mclk_in) begin
    prev_act <= (par_in[24] == stb_hi_in);
    if (prev_act && (par_in[24] != stb_hi_in)) begin
      word_out <= par_in;
      latch_cnt_out <= latch_cnt_out + 8'h01;
    end
  end
endmodule // spo_latch_model

// [dv/testbench.sv]
// Purpose: Self-checking bench for the scaled parallel output
// Assumes: MS_CYC shortened to 20, so one millisecond of the update period is 20 cycles
// Notes:   Link input idles high; no calc-done flag, so a fixed wait is used
`timescale 1ns/1ps
module testbench;
  import spo_pkg::*;
  logic        mclk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0, mv = 1'b0;
  logic [3:0]  addr = '0;
  logic [31:0] wd = '0, mval = '0, rdat, d;
  logic [24:0] par, word;
  logic [7:0]  lcnt;
  logic [2:0]  rtype;
  logic        irq, ren;
  logic        urx = 1'b1, pf = 1'b0;
  int          n_errors = 0, n_tests = 0;
  spo_top #(.MS_CYC(20)) spo_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdat),
    .uart_rx_in(urx), .meas_value_in(mval), .meas_valid_in(mv), .power_fail_in(pf),
    .par_out(par), .receiver_type_out(rtype), .receiver_en_out(ren), .irq_out(irq));
  spo_latch_model spo_latch_model_inst (.mclk_in(mclk_in), .stb_hi_in(1'b0),
    .par_in(par), .word_out(word), .latch_cnt_out(lcnt));
  initial forever #25 mclk_in = ~mclk_in;
  task wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    addr <= a;
    wd   <= v;
    wr   <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] exp);
    rd_reg(a, d);
    chk(d, exp);
  endtask
  // Calculation runs about 68 cycles; 100 leaves margin
  task meas(input logic [31:0] v);
    @(posedge mclk_in);
    mval <= v;
    mv   <= 1'b1;
    @(posedge mclk_in);
    mv <= 1'b0;
    repeat (100) @(posedge mclk_in);
  endtask
  // Start bit, eight data bits low first, stop bit
  task send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge mclk_in);
    for (int i = 0; i < 10; i++) begin
      urx <= f[i];
      repeat (BIT_CYC) @(posedge mclk_in);
    end
  endtask
  task tally_and_finish;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rchk(ADR_MULT, 32'h0000_0001);
    rchk(ADR_DIVR, 32'h0000_0001);
    rchk(ADR_OFFS, 32'h0000_0000);
    wr_reg(ADR_MODE, 32'h0000_0005);
    rchk(ADR_MODE, 32'h0000_0000);
    wr_reg(ADR_MULT, 32'h7000_0000);
    rchk(ADR_MULT, 32'h05F5_E0FF);
    wr_reg(ADR_DIVR, 32'h8000_0000);
    rchk(ADR_DIVR, 32'hFF67_6981);
    wr_reg(ADR_OFFS, 32'h8000_0000);
    rchk(ADR_OFFS, 32'hFF67_6981);
    wr_reg(ADR_DEFAULTS, 32'h0000_0001);
    rchk(ADR_MULT, 32'h0000_0001);
    rchk(ADR_OFFS, 32'h0000_0000);
    $display("test limits and defaults done");
    meas(32'h0000_0032);
    rchk(ADR_RESULT, 32'h0000_0000);
    chk({31'h0, ren}, 32'h0000_0000);
    wr_reg(ADR_MODE, 32'h0000_0002);
    wr_reg(ADR_MULT, 32'h0000_0003);
    wr_reg(ADR_DIVR, 32'h0000_0002);
    wr_reg(ADR_OFFS, 32'h0000_0005);
    wr_reg(ADR_PIN, 32'h0000_0002);
    wr_reg(ADR_UPD, 32'h0000_0001);
    meas(32'h0000_000A);
    rchk(ADR_RESULT, 32'h0000_0014);
    chk({31'h0, ren}, 32'h0000_0001);
    // First period still runs the 100 ms reset default
    while (lcnt < 8'h02) @(posedge mclk_in);
    chk({8'h00, word[23:0]}, 32'h0000_0014);
    wr_reg(ADR_DIR, 32'h0000_0001);
    meas(32'h0000_000A);
    rchk(ADR_RESULT, 32'hFFFF_FFF6);
    $display("test scaling and latch done");
    wr_reg(ADR_RETAIN, 32'h0000_0001);
    pf <= 1'b1;
    @(posedge mclk_in);
    pf <= 1'b0;
    rchk(ADR_RETAINED, 32'hFFFF_FFF6);
    wr_reg(ADR_GAIN, 32'h0002_0000);
    wr_reg(ADR_LIN, 32'h0000_0001);
    meas(32'h0000_000A);
    rchk(ADR_RESULT, 32'hFFFF_FFF6);
    wr_reg(ADR_LIN, 32'h0000_0002);
    meas(32'h0000_000A);
    rchk(ADR_RESULT, 32'hFFFF_FFEC);
    $display("test retain and curve done");
    wr_reg(ADR_DIR, 32'h0000_0000);
    wr_reg(ADR_MASK, 32'h0000_0001);
    wr_reg(ADR_MULT, 32'h05F5_E0FF);
    meas(32'h0000_03E8);
    chk({31'h0, irq}, 32'h0000_0001);
    repeat (80) @(posedge mclk_in);
    chk({8'h00, word[23:0]}, 32'h007F_FFFF);
    wr_reg(ADR_STATUS, 32'h0000_0001);
    repeat (3) @(posedge mclk_in);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test range error done");
    send_byte(8'h01);
    send_byte(8'h03);
    send_byte(8'h00);
    send_byte(8'h00);
    send_byte(8'h00);
    rchk(ADR_RTYPE, 32'h0000_0003);
    chk({29'h0, rtype}, 32'h0000_0003);
    wr_reg(ADR_PIN, 32'h0000_0005);
    repeat (3) @(posedge mclk_in);
    chk({31'h0, par[24]}, 32'h0000_0001);
    wr_reg(ADR_PIN, 32'h0000_0007);
    repeat (40) @(posedge mclk_in);
    chk({31'h0, par[23]}, 32'h0000_0001);
    $display("test link and error pin done");
    tally_and_finish();
  end
  // Whole run is under 12000 cycles, link frame included; this cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    tally_and_finish();
  end
endmodule // testbench
